// file: hdl/dpwr_top.sv
// Dual potentiometer wiper registers: wiper and stored-setting storage, power-up recall,
// write guard, frame detection and tap selection.
// Assumes the straps and the write guard change rarely, and that the bus master holds
// the serial clock high for a few device clocks around each start and stop condition.
`timescale 1ns/10ps

// What this block does
// - Separate 6-bit wiper register per potentiometer
// - 64 taps, full wiper code range
// - Four 6-bit stored settings per wiper
// - Power-up copies first stored setting to wiper
// - Registers written only by serial bus transactions
// - Guard low blocks stored writes, not wiper
// - Guard high or open: all writes normal
// - Bus address taken from four straps
// - Respond only when address field matches straps
// - Data line only pulled low, else released
// - Exactly one tap per potentiometer selected
module dpwr_top
   import dpwr_pkg::*;
#(
   parameter logic [WIPER_W-1:0] STORED_INIT = STORED_RESET
)
(
   // Device clock and reset.
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // Serial bus.
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   // Write guard, low blocks stored-setting writes.
   input wire logic WP_N_I,
   // Address straps, bit 0 to bit 3.
   input wire logic [STRAP_W-1:0] ADDR_STRAP_I,
   // Potentiometer control.
   output logic [NUM_POTS-1:0][WIPER_W-1:0] WIPER_POS_O,
   output logic [NUM_POTS-1:0][NUM_TAPS-1:0] TAP_SEL_O
);

   // Synchroniser stages and the agreed value of each crossing input.
   dpwr_pins_type pins_raw;
   dpwr_pins_type sync1_q;
   dpwr_pins_type sync2_q;
   dpwr_pins_type sync3_q;
   dpwr_pins_type stable_q, stable_d;
   dpwr_pins_type prev_q, prev_d;
   logic [$bits(dpwr_pins_type)-1:0] disagree;

   // Frame tracking.
   logic start_seen;
   logic stop_seen;
   logic link_rst_n_q, link_rst_n_d;

   // Register file and sequencing.
   dpwr_state_type state_q, state_d;
   dpwr_wiper_arr_type wiper_q, wiper_d;
   dpwr_stored_arr_type stored_q, stored_d;
   logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_q, tap_d;
   logic [STRAP_W-1:0] strap_q, strap_d;
   logic tog_seen_q, tog_seen_d;
   logic wr_event;
   logic guard_open;

   // Link side hand-over.
   dpwr_wr_req_type link_wr_req;
   logic link_wr_tog;
   logic link_sda_o;
   logic link_sda_oe;

   // Link clock activity, seen through a gray count of its rising edges, and the
   // number of device clocks for which that count has stood still.
   logic [1:0] scl_gray_q, scl_gray_d;
   logic [1:0] gray_s1_q;
   logic [1:0] gray_s2_q;
   logic [1:0] gray_s3_q;
   logic [QUIET_W-1:0] quiet_q, quiet_d;
   logic link_quiet;

   // Crossing inputs, grouped so they all see the same three-stage treatment.
   always_comb begin
      pins_raw.scl = SCL_I;
      pins_raw.sda = SDA_I;
      pins_raw.wp_n = WP_N_I;
      pins_raw.strap = ADDR_STRAP_I;
      pins_raw.wr_tog = link_wr_tog;
   end

   // A change only counts once the second and third stages agree, which also
   // swallows a one-cycle glitch on a slow pin.
   always_comb begin
      disagree = sync2_q ^ sync3_q;
      stable_d = (sync3_q & ~disagree) | (stable_q & disagree);
      prev_d = stable_q;
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync1_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b1, strap: '0, wr_tog: 1'b0};
         sync2_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b1, strap: '0, wr_tog: 1'b0};
         sync3_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b1, strap: '0, wr_tog: 1'b0};
         stable_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b1, strap: '0, wr_tog: 1'b0};
         prev_q <= '{scl: 1'b1, sda: 1'b1, wp_n: 1'b1, strap: '0, wr_tog: 1'b0};
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         stable_q <= stable_d;
         prev_q <= prev_d;
      end
   end

   // The link clock runs faster than this clock, so its sampled level aliases and
   // a running clock can look as if it stood high across a data change. A gray count
   // of its rising edges moves by two or three codes between two samples while it
   // runs, and only one bit changes at a time, so every sample is a valid code.
   always_comb begin
      scl_gray_d = {scl_gray_q[0], ~scl_gray_q[1]};
   end

   always_ff @(posedge SCL_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_gray_q <= 2'h0;
      end else begin
         scl_gray_q <= scl_gray_d;
      end
   end

   // The count crosses through its own three stages. Any difference between the
   // second and third stage is activity; start and stop are only believed once
   // the count has stood still for a few device clocks.
   always_comb begin
      quiet_d = quiet_q;
      if (gray_s2_q != gray_s3_q) begin
         quiet_d = '0;
      end else if (quiet_q != QUIET_MIN) begin
         quiet_d = quiet_q + 3'h1;
      end
      link_quiet = (quiet_q == QUIET_MIN);
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         gray_s1_q <= 2'h0;
         gray_s2_q <= 2'h0;
         gray_s3_q <= 2'h0;
         quiet_q <= '0;
      end else begin
         gray_s1_q <= scl_gray_q;
         gray_s2_q <= gray_s1_q;
         gray_s3_q <= gray_s2_q;
         quiet_q <= quiet_d;
      end
   end

   // Start is the data line falling and stop the data line rising, both while the
   // clock stands high. Sampling them here keeps the link engine free of a third clock.
   // Both also wait for a quiet link clock, so data bits inside a frame never count.
   always_comb begin
      start_seen = link_quiet && stable_q.scl && prev_q.scl && prev_q.sda && !stable_q.sda;
      stop_seen = link_quiet && stable_q.scl && prev_q.scl && !prev_q.sda && stable_q.sda;
      link_rst_n_d = link_rst_n_q;
      if (start_seen && state_q == ST_RUN) begin
         link_rst_n_d = 1'b1;
      end else if (stop_seen) begin
         link_rst_n_d = 1'b0;
      end
   end

   // The engine stays in reset between frames, so a frame always starts with the
   // address byte even if the previous one was cut short.
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         link_rst_n_q <= 1'b0;
      end else begin
         link_rst_n_q <= link_rst_n_d;
      end
   end

   // The straps are held in a register that the engine reads as a quasi-static
   // word; it only follows the pins while no frame is open.
   always_comb begin
      strap_d = strap_q;
      if (!link_rst_n_q) begin
         strap_d = stable_q.strap;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         strap_q <= '0;
      end else begin
         strap_q <= strap_d;
      end
   end

   // A toggle from the link marks one finished write. Events wait out the recall.
   // The toggle is cleared with the engine between frames; the seen copy follows it
   // then, so that clearing is not taken for a write. A write must be taken before
   // its stop, which the hold times around a stop leave ample room for.
   always_comb begin
      wr_event = (stable_q.wr_tog != tog_seen_q) && (state_q == ST_RUN) && link_rst_n_q;
      tog_seen_d = tog_seen_q;
      if (wr_event || !link_rst_n_q) begin
         tog_seen_d = stable_q.wr_tog;
      end
      // A floating guard pin is expected to be pulled high on the board.
      guard_open = stable_q.wp_n;
   end

   // Register file. The stored settings live in flip-flops here, so their content
   // is only as lasting as the reset domain; the reset value stands in for it.
   always_comb begin
      state_d = state_q;
      wiper_d = wiper_q;
      stored_d = stored_q;
      case (state_q)
         ST_RECALL: begin
            for (int p = 0; p < NUM_POTS; p++) begin
               wiper_d[p] = stored_q[p][RECALL_IDX];
            end
            state_d = ST_RUN;
         end
         ST_RUN: begin
            // Only the serial link ever writes these registers.
            if (wr_event) begin
               if (link_wr_req.stored) begin
                  if (guard_open) begin
                     stored_d[link_wr_req.pot][link_wr_req.idx] = link_wr_req.data;
                  end
                  // A guarded stored write is dropped here.
               end else begin
                  wiper_d[link_wr_req.pot] = link_wr_req.data;
               end
            end
         end
         default: begin
            state_d = ST_RECALL;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= ST_RECALL;
         wiper_q <= {NUM_POTS{WIPER_RESET}};
         stored_q <= {(NUM_POTS * NUM_STORED){STORED_INIT}};
         tog_seen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wiper_q <= wiper_d;
         stored_q <= stored_d;
         tog_seen_q <= tog_seen_d;
      end
   end

   // The tap select is decoded from the next wiper value so that it changes in the
   // same cycle as the wiper output, never showing two taps or none.
   generate
      for (genvar g = 0; g < NUM_POTS; g++) begin : g_tap
         always_comb begin
            tap_d[g] = NUM_TAPS'(1) << wiper_d[g];
         end
      end
   endgenerate

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tap_q <= {NUM_POTS{NUM_TAPS'(1) << WIPER_RESET}};
      end else begin
         tap_q <= tap_d;
      end
   end

   // The engine reads the register file and the straps without a synchroniser.
   // That is safe because none of them change while a read frame is open: the only
   // writer is the engine itself, and its writes land after the byte is done.
   dpwr_link u_link (
      .scl_i(SCL_I),
      .link_rst_n_i(link_rst_n_q),
      .sda_i(SDA_I),
      .sda_o(link_sda_o),
      .sda_oe_o(link_sda_oe),
      .strap_i(strap_q),
      .wiper_i(wiper_q),
      .stored_i(stored_q),
      .wr_req_o(link_wr_req),
      .wr_tog_o(link_wr_tog)
   );

   // Open-drain pin: the data output is always low, only the enable moves.
   assign SDA_O = link_sda_o;
   assign SDA_OE_O = link_sda_oe;
   assign WIPER_POS_O = wiper_q;
   assign TAP_SEL_O = tap_q;

endmodule : dpwr_top

// file: hdl/dpwr_pkg.sv
// Shared constants and carrier types for the dual potentiometer wiper register block.
// Assumes a device clock domain and a serial link domain clocked by the bus master.
package dpwr_pkg;

   // Array geometry.
   localparam int NUM_POTS = 2;
   localparam int WIPER_W = 6;
   localparam int NUM_STORED = 4;
   localparam int STORED_IDX_W = 2;
   localparam int NUM_TAPS = 64;
   localparam int STRAP_W = 4;

   // Serial framing.
   localparam int BYTE_W = 8;
   localparam int BIT_CNT_W = 4;
   localparam logic [BIT_CNT_W-1:0] LAST_DATA_BIT = 4'h7;
   localparam logic [BIT_CNT_W-1:0] ACK_SLOT = 4'h8;

   // Device clocks the link clock must stand still before a start or stop counts.
   localparam int QUIET_W = 3;
   localparam logic [QUIET_W-1:0] QUIET_MIN = 3'h4;

   // Address byte and select byte field positions.
   localparam int ADDR_FIELD_LSB = 4;
   localparam int RW_BIT = 0;
   localparam int SEL_POT_BIT = 4;
   localparam int SEL_STORED_BIT = 3;
   localparam int SEL_IDX_LSB = 0;

   // Reset values and recall source.
   localparam logic [WIPER_W-1:0] WIPER_RESET = 6'h00;
   localparam logic [WIPER_W-1:0] STORED_RESET = 6'h00;
   localparam logic [STORED_IDX_W-1:0] RECALL_IDX = 2'h0;

   typedef logic [NUM_POTS-1:0][WIPER_W-1:0] dpwr_wiper_arr_type;
   typedef logic [NUM_POTS-1:0][NUM_STORED-1:0][WIPER_W-1:0] dpwr_stored_arr_type;

   // One write captured on the link, handed to the device clock domain.
   typedef struct packed {
      logic stored;
      logic pot;
      logic [STORED_IDX_W-1:0] idx;
      logic [WIPER_W-1:0] data;
   } dpwr_wr_req_type;

   // Inputs that cross into the device clock domain.
   typedef struct packed {
      logic scl;
      logic sda;
      logic wp_n;
      logic [STRAP_W-1:0] strap;
      logic wr_tog;
   } dpwr_pins_type;

   typedef enum logic {ST_RECALL, ST_RUN} dpwr_state_type;
   typedef enum logic [2:0] {LS_ADDR, LS_CMD, LS_WRITE, LS_READ, LS_IGNORE} dpwr_link_state_type;

endpackage : dpwr_pkg

// file: hdl/dpwr_link.sv
// Serial link engine: shifts bytes on the bus master's clock and answers on the data line.
// Assumes the reset input is released only while the serial clock stands high after a
// start condition, and that the register words it reads stay still during a frame.
`timescale 1ns/10ps
module dpwr_link
   import dpwr_pkg::*;
(
   // Link clock and frame reset.
   input wire logic scl_i,
   input wire logic link_rst_n_i,
   // Serial data pin.
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Quasi-static state of the device domain.
   input wire logic [STRAP_W-1:0] strap_i,
   input wire dpwr_wiper_arr_type wiper_i,
   input wire dpwr_stored_arr_type stored_i,
   // Write hand-over.
   output dpwr_wr_req_type wr_req_o,
   output logic wr_tog_o
);

   dpwr_link_state_type st_q, st_d;
   logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [BYTE_W-1:0] sel_q, sel_d;
   logic [BYTE_W-1:0] byte_in;
   logic [BYTE_W-1:0] rd_byte;
   logic [WIPER_W-1:0] rd_word;
   logic rw_q, rw_d;
   logic ack_q, ack_d;
   logic oe_q, oe_d;
   logic sda_q;
   dpwr_wr_req_type wr_req_q, wr_req_d;
   logic wr_tog_q, wr_tog_d;

   // Every bit is sampled on the rising edge of the master's clock.
   always_comb begin
      st_d = st_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      sel_d = sel_q;
      rw_d = rw_q;
      ack_d = ack_q;
      wr_req_d = wr_req_q;
      wr_tog_d = wr_tog_q;
      byte_in = {shift_q[BYTE_W-2:0], sda_i};
      if (bit_cnt_q == ACK_SLOT) begin
         bit_cnt_d = '0;
         ack_d = 1'b0;
         // A high level in the master's answer slot ends a read.
         if (st_q == LS_READ && sda_i) begin
            st_d = LS_IGNORE;
         end
      end else begin
         shift_d = byte_in;
         bit_cnt_d = bit_cnt_q + 4'h1;
         if (bit_cnt_q == LAST_DATA_BIT) begin
            case (st_q)
               LS_ADDR: begin
                  if (byte_in[ADDR_FIELD_LSB +: STRAP_W] == strap_i) begin
                     ack_d = 1'b1;
                     rw_d = byte_in[RW_BIT];
                     st_d = LS_CMD;
                  end else begin
                     st_d = LS_IGNORE;
                  end
               end
               LS_CMD: begin
                  ack_d = 1'b1;
                  sel_d = byte_in;
                  st_d = rw_q ? LS_READ : LS_WRITE;
               end
               LS_WRITE: begin
                  ack_d = 1'b1;
                  wr_req_d.stored = sel_q[SEL_STORED_BIT];
                  wr_req_d.pot = sel_q[SEL_POT_BIT];
                  wr_req_d.idx = sel_q[SEL_IDX_LSB +: STORED_IDX_W];
                  wr_req_d.data = byte_in[WIPER_W-1:0];
                  wr_tog_d = ~wr_tog_q;
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge scl_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         st_q <= LS_ADDR;
         bit_cnt_q <= '0;
         shift_q <= '0;
         sel_q <= '0;
         rw_q <= 1'b0;
         ack_q <= 1'b0;
         wr_tog_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         sel_q <= sel_d;
         rw_q <= rw_d;
         ack_q <= ack_d;
         wr_tog_q <= wr_tog_d;
      end
   end

   // The write request outlives the frame, but the device domain must still take it before the stop.
   // The toggle that announces it is cleared with the frame; the device domain follows
   // that clearing between frames instead of taking it for a write.
   always_ff @(posedge scl_i) begin
      wr_req_q <= wr_req_d;
   end

   always_comb begin
      rd_word = sel_q[SEL_STORED_BIT] ?
         stored_i[sel_q[SEL_POT_BIT]][sel_q[SEL_IDX_LSB +: STORED_IDX_W]] :
         wiper_i[sel_q[SEL_POT_BIT]];
      rd_byte = {{(BYTE_W-WIPER_W){1'b0}}, rd_word};
      oe_d = 1'b0;
      if (bit_cnt_q == ACK_SLOT) begin
         oe_d = ack_q;
      end else if (st_q == LS_READ) begin
         oe_d = ~rd_byte[3'h7 - bit_cnt_q[2:0]];
      end
   end

   // The line is only ever pulled low; a one is sent by letting go.
   always_ff @(negedge scl_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         oe_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
         sda_q <= 1'b0;
      end
   end

   assign sda_o = sda_q;
   assign sda_oe_o = oe_q;
   assign wr_req_o = wr_req_q;
   assign wr_tog_o = wr_tog_q;

endmodule : dpwr_link

// file: verif/dpwr_props.sv
// Checker for the dual wiper register block, watching only the top ports.
// Assumes it is bound to dpwr_top with the same STORED_INIT value.
`timescale 1ns/10ps
module dpwr_props
   import dpwr_pkg::*;
#(
   parameter logic [WIPER_W-1:0] STORED_INIT = STORED_RESET
)
(
   // Clock, reset and serial pins.
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_O,
   // Static inputs.
   input wire logic WP_N_I,
   input wire logic [STRAP_W-1:0] ADDR_STRAP_I,
   // Potentiometer outputs.
   input wire logic [NUM_POTS-1:0][WIPER_W-1:0] WIPER_POS_O,
   input wire logic [NUM_POTS-1:0][NUM_TAPS-1:0] TAP_SEL_O
);
   // A link clock edge count always moves between device clocks while the link runs,
   // whereas a sampled clock level would alias against the device clock.
   logic [7:0] scl_cnt_q;
   logic [7:0] scl_seen_q;
   logic [3:0] idle_q;
   logic [3:0] idle_d;

   always_ff @(posedge SCL_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_cnt_q <= 8'h00;
      end else begin
         scl_cnt_q <= scl_cnt_q + 8'h01;
      end
   end

   always_comb begin
      idle_d = idle_q;
      if (scl_seen_q != scl_cnt_q) begin
         idle_d = 4'h0;
      end else if (idle_q != 4'hF) begin
         idle_d = idle_q + 4'h1;
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scl_seen_q <= 8'h00;
         idle_q <= 4'hF;
      end else begin
         scl_seen_q <= scl_cnt_q;
         idle_q <= idle_d;
      end
   end

   sequence s_link_busy;
      idle_q < 4'hC;
   endsequence

   a_data_low_only: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      SDA_O == 1'b0) else $error("data output not low");
   a_drive_pulls_low: assert property (@(posedge SCL_I) disable iff (!RST_N_I)
      SDA_OE_O |-> !SDA_I) else $error("driven data line not low");
   a_release_quiet: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(RST_N_I) |-> !SDA_OE_O) else $error("data line driven after reset");
   a_drive_in_frame: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      SDA_OE_O |-> s_link_busy) else $error("data line driven while link idle");
   a_tap_one_hot: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      $onehot(TAP_SEL_O[0]) && $onehot(TAP_SEL_O[1])) else $error("tap select not one-hot");
   a_tap_follows_wiper: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      TAP_SEL_O[0] == (64'h1 << WIPER_POS_O[0]) && TAP_SEL_O[1] == (64'h1 << WIPER_POS_O[1]))
      else $error("tap select differs from wiper");
   a_recall_first_setting: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      !$past(RST_N_I) |=> WIPER_POS_O == {STORED_INIT, STORED_INIT})
      else $error("wiper not recalled");
   a_wiper_by_bus: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
      $changed(WIPER_POS_O) && $past(RST_N_I, 2) |-> s_link_busy)
      else $error("wiper changed without bus traffic");
endmodule : dpwr_props

// file: verif/dpwr_host.sv
// Bus master model for the two-wire serial link: makes the link clock and pulls data low.
// Assumes the data line is pulled up and resolved outside this model.
`timescale 1ns/10ps
module dpwr_host (
   // Link clock and data pull-down.
   output logic scl_o,
   output logic sda_low_o,
   // Resolved data line.
   input wire logic sda_i
);
   localparam int HALF = 6;
   localparam int HOLD = 160;

   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // The long holds let the device clock see start and stop around a still link clock.
   task automatic start_cond();
      sda_low_o = 1'b0;
      #HOLD;
      sda_low_o = 1'b1;
      #HOLD;
   endtask : start_cond

   task automatic stop_cond();
      scl_o = 1'b0;
      #(HALF / 2);
      sda_low_o = 1'b1;
      #(HALF / 2);
      scl_o = 1'b1;
      #HOLD;
      sda_low_o = 1'b0;
      #HOLD;
   endtask : stop_cond

   // Data changes only while the clock is low; the level is taken at the rising edge.
   task automatic clk_bit(input logic low, output logic seen);
      scl_o = 1'b0;
      #(HALF / 2);
      sda_low_o = low;
      #(HALF / 2);
      scl_o = 1'b1;
      seen = sda_i;
      #HALF;
   endtask : clk_bit

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(!b[i], s);
      end
      clk_bit(1'b0, s);
      ack = !s;
   endtask : put_byte

   task automatic get_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b0, s);
         b[i] = s;
      end
      clk_bit(more, s);
   endtask : get_byte
endmodule : dpwr_host

// file: verif/dpwr_top_tb.sv
// Self-checking bench for the dual wiper register block, driven by the bus master model.
// Assumes a pulled-up data line shared by the device and the master model.
`timescale 1ns/10ps
module dpwr_top_tb;
   import dpwr_pkg::*;
   localparam logic [WIPER_W-1:0] INIT = 6'h15;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic [STRAP_W-1:0] strap = 4'h5;
   logic scl;
   logic m_low;
   logic sda;
   logic sda_o;
   logic sda_oe;
   dpwr_wiper_arr_type wiper;
   logic [NUM_POTS-1:0][NUM_TAPS-1:0] taps;
   logic [7:0] rd;
   int fail_count = 0;
   int total_checks = 0;

   assign sda = (sda_oe || m_low) ? 1'b0 : 1'b1;
   always #12.5 mclk = ~mclk;

   dpwr_top #(.STORED_INIT(INIT)) u_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WP_N_I(wp_n), .ADDR_STRAP_I(strap),
      .WIPER_POS_O(wiper), .TAP_SEL_O(taps));
   dpwr_host u_host (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] sel, input logic [7:0] d,
                         input logic ok);
      logic a0, a1, a2;
      u_host.start_cond();
      u_host.put_byte({a, 4'h0}, a0);
      u_host.put_byte(sel, a1);
      u_host.put_byte(d, a2);
      u_host.stop_cond();
      check(a0 & a1 & a2, ok);
      repeat (8) @(negedge mclk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] sel, output logic [7:0] v);
      logic a0, a1;
      u_host.start_cond();
      u_host.put_byte({strap, 4'h1}, a0);
      u_host.put_byte(sel, a1);
      u_host.get_byte(1'b0, v);
      u_host.stop_cond();
      check(a0 & a1, 1'b1);
      repeat (8) @(negedge mclk);
   endtask : rd_reg

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic do_reset();
      @(negedge mclk) rst_n = 1'b0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      check(wiper, {INIT, INIT});
      check(taps[1], 64'h1 << INIT);
   endtask : do_reset

   initial begin
      do_reset();
      wr_reg(4'h5, 8'h00, 8'h3F, 1'b1);
      wr_reg(4'h5, 8'h10, 8'hEA, 1'b1);
      check(wiper, {6'h2A, 6'h3F});
      check(taps[0], 64'h1 << 6'h3F);
      check(taps[1], 64'h1 << 6'h2A);
      rd_reg(8'h00, rd);
      check(rd, 8'h3F);
      for (int i = 0; i < 4; i++) begin
         wr_reg(4'h5, {6'h06, i[1:0]}, {6'h0C, i[1:0]}, 1'b1);
         rd_reg({6'h06, i[1:0]}, rd);
         check(rd, {6'h0C, i[1:0]});
      end
      check(wiper, {6'h2A, 6'h3F});
      @(negedge mclk) wp_n = 1'b0;
      wr_reg(4'h5, 8'h1B, 8'h01, 1'b1);
      rd_reg(8'h1B, rd);
      check(rd, 8'h33);
      wr_reg(4'h5, 8'h10, 8'h05, 1'b1);
      check(wiper[1], 6'h05);
      @(negedge mclk) wp_n = 1'b1;
      for (int b = 0; b < 4; b++) begin
         wr_reg(4'h5 ^ (4'h1 << b), 8'h00, 8'h00, 1'b0);
      end
      check(wiper[0], 6'h3F);
      @(negedge mclk) strap = 4'hA;
      wr_reg(4'hA, 8'h00, 8'h00, 1'b1);
      check(wiper[0], 6'h00);
      wr_reg(4'hA, 8'h08, 8'h0C, 1'b1);
      rd_reg(8'h08, rd);
      check(rd, 8'h0C);
      do_reset();
      final_report();
   end

   initial begin
      #200000;
      fail_count++;
      final_report();
   end
endmodule : dpwr_top_tb

bind dpwr_top dpwr_props #(.STORED_INIT(STORED_INIT)) u_props (.MCLK_I(MCLK_I),
   .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
   .WP_N_I(WP_N_I), .ADDR_STRAP_I(ADDR_STRAP_I), .WIPER_POS_O(WIPER_POS_O),
   .TAP_SEL_O(TAP_SEL_O));
